// *** hw/dma_params.svh ***
// Offsets, field positions, an unused last-channel code and request codes of the
// eight-channel transfer controller.
// Assumes inclusion by the controller module only.
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH

// ----------------------------------------
// Register map (word index on the register port)
// ----------------------------------------
// Channel slots: index = channel * 8 + slot
`define OFS_CHANNEL_CONTROL  3'h0
`define OFS_REQUEST_SELECT   3'h1
`define OFS_PRIMARY_START    3'h2
`define OFS_SECONDARY_START  3'h3
`define OFS_PERIPHERAL_ADDR  3'h4
`define OFS_TRANSFER_COUNT   3'h5
`define OFS_COLLISION_STATUS 7'h40
`define OFS_CHANNEL_STATUS   7'h41

// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define CON_ENABLE_BIT   15
`define CON_SIZE_BIT     14
`define CON_DIR_BIT      13
`define CON_HALF_BIT     12
`define CON_NULL_WRITE_SELECT_BIT    11
`define CON_ADDRESSING_MODE_HI     5
`define CON_ADDRESSING_MODE_LO     4
`define CON_MODE_HI      1
`define CON_MODE_LO      0
`define CON_WRITE_MASK   16'hF833
`define ADDRESSING_MODE_POST_INC   2'h0
`define MODE_ONE_SHOT    2'h1
`define MODE_ONE_SHOT_PP 2'h3
`define REQ_FORCE_BIT    15

// ----------------------------------------
// Unused last-channel code (reset clears last_ch) and request source examples
// ----------------------------------------
`define LAST_CHANNEL_NONE 4'hF
`define REQ_CODE_ADC_DONE  7'h0D
`define PERIPH_ADDR_ADC    16'h0300
`define REQ_CODE_SER1_DONE 7'h0A
`define PERIPH_ADDR_SER1   16'h0248

`endif

// *** hw/dma_pkg.sv ***
// Types shared by the transfer controller and its surroundings.
// Assumes nothing beyond the parameter header.
package dma_pkg;

   // ----------------------------------------
   // Transfer sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_LATCH = 2'b10,
      ST_WRITE = 2'b11
   } xfer_state_type;

   // Dedicated transfer bus towards DMA RAM and peripherals
   typedef struct packed {
      logic [15:0] ram_addr;
      logic [15:0] ram_wdata;
      logic [1:0]  ram_be;
      logic        ram_re;
      logic        ram_we;
      logic [15:0] per_addr;
      logic [15:0] per_wdata;
      logic        per_re;
      logic        per_we;
   } xfer_bus_type;

   // Whole state of the controller
   typedef struct packed {
      logic [7:0][15:0] con;
      logic [7:0][6:0]  req_sel;
      logic [7:0]       force_req;
      logic [7:0][15:0] sta;
      logic [7:0][15:0] stb;
      logic [7:0][15:0] pad;
      logic [7:0][9:0]  cnt;
      logic [7:0][15:0] ptr;
      logic [7:0][9:0]  done;
      logic [7:0]       ppst;
      logic [7:0]       pend;
      logic [7:0]       ram_col;
      logic [7:0]       per_col;
      logic [3:0]       last_ch;
      xfer_state_type   state;
      logic [2:0]       cur_ch;
      logic [7:0]       irq;
      logic [15:0]      rd_data;
      xfer_bus_type     bus;
   } dma_state_type;

endpackage

// *** hw/multi_channel_dma_controller.sv ***
// Eight-channel transfer controller between peripherals and DMA RAM.
// Assumes the register port, peripheral requests, RAM and peripherals
// all run on ref_clk; read data return one cycle after a read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "dma_params.svh"

module multi_channel_dma_controller (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic [6:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [15:0]              reg_rdata,
   input  wire logic [127:0]        periph_irq,
   input  wire logic [7:0][15:0]    periph_ram_addr,
   output var dma_pkg::xfer_bus_type xfer_bus,
   input  wire logic [15:0]         ram_rdata,
   input  wire logic [15:0]         per_rdata,
   input  wire logic                cpu_ram_we,
   input  wire logic [15:0]         cpu_ram_addr,
   input  wire logic                cpu_per_we,
   input  wire logic [15:0]         cpu_per_addr,
   output logic [7:0]               channel_irq_flag
);

   // ----------------------------------------
   // State and helpers
   // ----------------------------------------
   dma_pkg::dma_state_type cur_ff;
   dma_pkg::dma_state_type nxt_cur;
   logic [7:0]             want;
   logic [2:0]             pick;

   // Lowest set bit wins
   // lowest channel wins
   function automatic logic [2:0] lowest(input logic [7:0] vec);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (vec[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Channels asking for service
   // software or peripheral start
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         want[c] = (cur_ff.pend[c] | cur_ff.force_req[c]) & cur_ff.con[c][`CON_ENABLE_BIT];
      end
   end

   assign pick = lowest(want);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic [2:0]  ch;
      logic [2:0]  wch;
      logic [15:0] con;
      logic [15:0] data;
      logic [15:0] raddr;
      logic        new_pp;
      nxt_cur = cur_ff;
      ch      = cur_ff.cur_ch;
      wch     = reg_addr[5:3];
      con     = cur_ff.con[ch];
      data    = 16'h0000;
      raddr   = 16'h0000;
      new_pp  = 1'b0;
      nxt_cur.irq        = 8'h00;
      nxt_cur.rd_data    = 16'h0000;
      nxt_cur.bus.ram_re = 1'b0;
      nxt_cur.bus.ram_we = 1'b0;
      nxt_cur.bus.per_re = 1'b0;
      nxt_cur.bus.per_we = 1'b0;

      // Capture peripheral requests of enabled channels
      // code selects source
      for (int c = 0; c < 8; c++) begin
         if (cur_ff.con[c][`CON_ENABLE_BIT] && periph_irq[cur_ff.req_sel[c]]) begin
            nxt_cur.pend[c] = 1'b1;
         end
      end

      // Transfer sequencer: read, latch, write
      // own bus
      case (cur_ff.state)
         dma_pkg::ST_IDLE: begin
            if (want != 8'h00) begin
               ch    = pick;
               con   = cur_ff.con[ch];
               raddr = con[`CON_ADDRESSING_MODE_HI] ? periph_ram_addr[ch] : cur_ff.ptr[ch];
               nxt_cur.cur_ch       = ch;
               nxt_cur.last_ch      = {1'b0, ch};
               // A request arriving in the grant cycle stays pending
               nxt_cur.pend[ch]     = periph_irq[cur_ff.req_sel[ch]];
               nxt_cur.bus.ram_addr = raddr;
               nxt_cur.bus.per_addr = cur_ff.pad[ch];
               if (con[`CON_SIZE_BIT]) begin
                  nxt_cur.bus.ram_be = raddr[0] ? 2'b10 : 2'b01;
               end else begin
                  nxt_cur.bus.ram_be = 2'b11;
               end
               nxt_cur.bus.ram_re = con[`CON_DIR_BIT];
               nxt_cur.bus.per_re = ~con[`CON_DIR_BIT];
               nxt_cur.state      = dma_pkg::ST_READ;
            end
         end
         dma_pkg::ST_READ: begin
            nxt_cur.state = dma_pkg::ST_LATCH;
         end
         dma_pkg::ST_LATCH: begin
            data = con[`CON_DIR_BIT] ? ram_rdata : per_rdata;
            if (con[`CON_DIR_BIT]) begin
               nxt_cur.bus.per_we    = 1'b1;
               nxt_cur.bus.per_wdata = data;
            end else begin
               nxt_cur.bus.ram_we    = 1'b1;
               nxt_cur.bus.ram_wdata = data;
               if (con[`CON_NULL_WRITE_SELECT_BIT]) begin
                  nxt_cur.bus.per_we    = 1'b1;
                  nxt_cur.bus.per_wdata = 16'h0000;
               end
            end
            nxt_cur.state = dma_pkg::ST_WRITE;
         end
         dma_pkg::ST_WRITE: begin
            nxt_cur.force_req[ch] = 1'b0;
            if (con[`CON_ADDRESSING_MODE_HI:`CON_ADDRESSING_MODE_LO] == `ADDRESSING_MODE_POST_INC) begin
               nxt_cur.ptr[ch] = cur_ff.ptr[ch] + (con[`CON_SIZE_BIT] ? 16'h0001 : 16'h0002);
            end
            if (cur_ff.done[ch] == cur_ff.cnt[ch]) begin
               nxt_cur.done[ch] = 10'h000;
               new_pp = con[`CON_MODE_HI] & ~cur_ff.ppst[ch];
               nxt_cur.ppst[ch] = new_pp;
               nxt_cur.ptr[ch]  = new_pp ? cur_ff.stb[ch] : cur_ff.sta[ch];
               nxt_cur.irq[ch] = ~con[`CON_HALF_BIT];
               if ((con[`CON_MODE_HI:`CON_MODE_LO] == `MODE_ONE_SHOT) ||
                   ((con[`CON_MODE_HI:`CON_MODE_LO] == `MODE_ONE_SHOT_PP) && cur_ff.ppst[ch])) begin
                  nxt_cur.con[ch][`CON_ENABLE_BIT] = 1'b0;
               end
            end else begin
               nxt_cur.done[ch] = cur_ff.done[ch] + 10'h001;
            end
            if (con[`CON_HALF_BIT] && (cur_ff.done[ch] == (cur_ff.cnt[ch] >> 1))) begin
               nxt_cur.irq[ch] = 1'b1;
            end
            nxt_cur.state = dma_pkg::ST_IDLE;
         end
         default: begin
            nxt_cur.state = dma_pkg::ST_IDLE;
         end
      endcase

      // Software writes to the register port
      // per-channel register slots
      if (reg_wr && !reg_addr[6]) begin
         case (reg_addr[2:0])
            `OFS_CHANNEL_CONTROL: begin
               nxt_cur.con[wch] = reg_wdata & `CON_WRITE_MASK;
               if (reg_wdata[`CON_ENABLE_BIT] && !cur_ff.con[wch][`CON_ENABLE_BIT]) begin
                  nxt_cur.ptr[wch]  = cur_ff.sta[wch];
                  nxt_cur.done[wch] = 10'h000;
                  nxt_cur.ppst[wch] = 1'b0;
                  nxt_cur.pend[wch] = 1'b0;
               end
            end
            `OFS_REQUEST_SELECT: begin
               nxt_cur.req_sel[wch] = reg_wdata[6:0];
               if (reg_wdata[`REQ_FORCE_BIT]) begin
                  nxt_cur.force_req[wch] = 1'b1;
               end
            end
            `OFS_PRIMARY_START: begin
               nxt_cur.sta[wch] = reg_wdata;
               if (!cur_ff.con[wch][`CON_ENABLE_BIT] && !cur_ff.ppst[wch]) begin
                  nxt_cur.ptr[wch] = reg_wdata;
               end
            end
            `OFS_SECONDARY_START: begin
               nxt_cur.stb[wch] = reg_wdata;
               if (!cur_ff.con[wch][`CON_ENABLE_BIT] && cur_ff.ppst[wch]) begin
                  nxt_cur.ptr[wch] = reg_wdata;
               end
            end
            `OFS_PERIPHERAL_ADDR: begin
               nxt_cur.pad[wch] = reg_wdata;
            end
            `OFS_TRANSFER_COUNT: begin
               nxt_cur.cnt[wch] = reg_wdata[9:0];
            end
            default: begin
            end
         endcase
      end

      // Collision flags clear on writing zero
      if (reg_wr && (reg_addr == `OFS_COLLISION_STATUS)) begin
         nxt_cur.per_col = cur_ff.per_col & reg_wdata[15:8];
         nxt_cur.ram_col = cur_ff.ram_col & reg_wdata[7:0];
      end

      // Collision set wins over a clear in the same cycle
      // write collision detection
      if (cur_ff.state == dma_pkg::ST_WRITE) begin
         if (cur_ff.bus.ram_we && cpu_ram_we && (cpu_ram_addr == cur_ff.bus.ram_addr)) begin
            nxt_cur.ram_col[ch] = 1'b1;
         end
         if (cur_ff.bus.per_we && cpu_per_we && (cpu_per_addr == cur_ff.bus.per_addr)) begin
            nxt_cur.per_col[ch] = 1'b1;
         end
      end

      // Read data, one cycle after the strobe
      if (reg_rd) begin
         if (reg_addr == `OFS_COLLISION_STATUS) begin
            nxt_cur.rd_data = {cur_ff.per_col, cur_ff.ram_col};
         end else if (reg_addr == `OFS_CHANNEL_STATUS) begin
            nxt_cur.rd_data = {4'h0, cur_ff.last_ch, cur_ff.ppst};
         end else if (!reg_addr[6]) begin
            case (reg_addr[2:0])
               `OFS_CHANNEL_CONTROL: nxt_cur.rd_data = cur_ff.con[wch];
               `OFS_REQUEST_SELECT:  nxt_cur.rd_data = {cur_ff.force_req[wch], 8'h00,
                                                        cur_ff.req_sel[wch]};
               `OFS_PRIMARY_START:   nxt_cur.rd_data = cur_ff.ptr[wch];
               `OFS_SECONDARY_START: nxt_cur.rd_data = cur_ff.ptr[wch];
               `OFS_PERIPHERAL_ADDR: nxt_cur.rd_data = cur_ff.pad[wch];
               `OFS_TRANSFER_COUNT:  nxt_cur.rd_data = {6'h00, cur_ff.cnt[wch]};
               default:              nxt_cur.rd_data = 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata        = cur_ff.rd_data;
   assign xfer_bus         = cur_ff.bus;
   assign channel_irq_flag = cur_ff.irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence xfer_seq;
      cur_ff.state == dma_pkg::ST_READ ##1 cur_ff.state == dma_pkg::ST_LATCH
         ##1 cur_ff.state == dma_pkg::ST_WRITE ##1 cur_ff.state == dma_pkg::ST_IDLE;
   endsequence

   reserved_zero_a: assert property (
      (reg_rd && !reg_addr[6] && reg_addr[2:0] == `OFS_CHANNEL_CONTROL)
      |=> (reg_rdata[10:6] == 5'h00 && reg_rdata[3:2] == 2'h0))
      else $error("Unused control bits read nonzero");

   lowest_grant_a: assert property (
      (cur_ff.state == dma_pkg::ST_IDLE && want != 8'h00)
      |=> ((($past(want) >> cur_ff.cur_ch) & 8'h01) == 8'h01
           && ($past(want) & ((8'h01 << cur_ff.cur_ch) - 8'h01)) == 8'h00
           && cur_ff.state == dma_pkg::ST_READ))
      else $error("Grant not given to lowest channel");

   xfer_steps_a: assert property (
      (cur_ff.state == dma_pkg::ST_IDLE && want != 8'h00) |=> xfer_seq)
      else $error("Transfer sequence broken");

   dir_write_a: assert property (
      (cur_ff.state == dma_pkg::ST_WRITE && cur_ff.con[cur_ff.cur_ch][`CON_DIR_BIT])
      |-> (cur_ff.bus.per_we && !cur_ff.bus.ram_we && $past(cur_ff.bus.ram_re, 2)))
      else $error("Direction not honoured");

   null_write_a: assert property (
      (cur_ff.state == dma_pkg::ST_WRITE && !cur_ff.con[cur_ff.cur_ch][`CON_DIR_BIT]
       && cur_ff.con[cur_ff.cur_ch][`CON_NULL_WRITE_SELECT_BIT])
      |-> (cur_ff.bus.ram_we && cur_ff.bus.per_we && cur_ff.bus.per_wdata == 16'h0000))
      else $error("Null write missing");

   byte_lane_a: assert property (
      (cur_ff.state == dma_pkg::ST_READ && cur_ff.con[cur_ff.cur_ch][`CON_SIZE_BIT])
      |-> (cur_ff.bus.ram_be == 2'b01 || cur_ff.bus.ram_be == 2'b10))
      else $error("Byte transfer drives both lanes");

   force_clear_a: assert property (
      $fell(cur_ff.force_req[0]) |-> ($past(cur_ff.state) == dma_pkg::ST_WRITE
                                     && $past(cur_ff.cur_ch) == 3'h0))
      else $error("Force bit cleared outside transfer end");

   one_shot_a: assert property (
      (channel_irq_flag[0] && !cur_ff.con[0][`CON_HALF_BIT]
       && cur_ff.con[0][`CON_MODE_HI:`CON_MODE_LO] == `MODE_ONE_SHOT
       && !$past(reg_wr))
      |-> !cur_ff.con[0][`CON_ENABLE_BIT])
      else $error("One-shot channel still enabled");

   block_irq_a: assert property (
      (cur_ff.state == dma_pkg::ST_WRITE
       && (cur_ff.con[cur_ff.cur_ch][`CON_HALF_BIT]
           ? (cur_ff.done[cur_ff.cur_ch] == (cur_ff.cnt[cur_ff.cur_ch] >> 1))
           : (cur_ff.done[cur_ff.cur_ch] == cur_ff.cnt[cur_ff.cur_ch])))
      |=> (channel_irq_flag == $past(8'h01 << cur_ff.cur_ch)))
      else $error("Block interrupt missing or misplaced");

   ping_pong_swap_a: assert property (
      (cur_ff.state == dma_pkg::ST_WRITE && !reg_wr
       && cur_ff.con[cur_ff.cur_ch][`CON_MODE_HI]
       && cur_ff.done[cur_ff.cur_ch] == cur_ff.cnt[cur_ff.cur_ch])
      |=> (((cur_ff.ppst ^ $past(cur_ff.ppst)) & $past(8'h01 << cur_ff.cur_ch)) != 8'h00))
      else $error("Ping-pong buffer not swapped");

   ram_collision_a: assert property (
      (cur_ff.state == dma_pkg::ST_WRITE && cur_ff.bus.ram_we && cpu_ram_we
       && cpu_ram_addr == cur_ff.bus.ram_addr)
      |=> ((cur_ff.ram_col & $past(8'h01 << cur_ff.cur_ch)) != 8'h00))
      else $error("RAM write collision not flagged");

   irq_quiet_a: assert property (
      (cur_ff.state != dma_pkg::ST_WRITE) |=> (channel_irq_flag == 8'h00))
      else $error("Interrupt flag outside transfer end");

endmodule
`default_nettype wire

// *** bench/dma_far_side.sv ***
// Far-side model: DMA RAM and peripheral registers on the transfer bus.
// Assumes the controller's bus struct and one shared clock with it.
`timescale 1ns/10ps
`default_nettype none

module dma_far_side (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire dma_pkg::xfer_bus_type xfer_bus,
   output logic [15:0]                ram_rdata,
   output logic [15:0]                per_rdata
);
   logic [15:0] mem [0:63];

   // ----------------------------------------
   // Read answers
   // ----------------------------------------
   // Data stand the cycle after a strobe; an idle bus flips so stale values never match
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ram_rdata <= 16'h0000;
         per_rdata <= 16'h0000;
      end else begin
         ram_rdata <= xfer_bus.ram_re ? mem[xfer_bus.ram_addr[6:1]] : ~ram_rdata;
         per_rdata <= xfer_bus.per_re ? (xfer_bus.per_addr ^ 16'hA5A5) : ~per_rdata;
      end
   end

   // RAM write with byte lanes
   always @(posedge ref_clk) begin
      if (xfer_bus.ram_we && xfer_bus.ram_be[0]) begin
         mem[xfer_bus.ram_addr[6:1]][7:0] <= xfer_bus.ram_wdata[7:0];
      end
      if (xfer_bus.ram_we && xfer_bus.ram_be[1]) begin
         mem[xfer_bus.ram_addr[6:1]][15:8] <= xfer_bus.ram_wdata[15:8];
      end
   end
endmodule

`default_nettype wire

// *** bench/multi_channel_dma_controller_bench.sv ***
// Self-checking bench for the eight-channel transfer controller.
// Assumes the far-side model answers reads one cycle after each strobe.
`timescale 1ns/10ps
`default_nettype none

module multi_channel_dma_controller_bench;
   logic                  ref_clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic [6:0]            reg_addr = 7'h00;
   logic [15:0]           reg_wdata = 16'h0000;
   logic                  reg_wr = 1'b0;
   logic                  reg_rd = 1'b0;
   logic [15:0]           reg_rdata;
   logic [127:0]          periph_irq = 128'h0;
   logic [7:0][15:0]      periph_ram_addr = 128'h0;
   dma_pkg::xfer_bus_type xfer_bus;
   logic [15:0]           ram_rdata;
   logic [15:0]           per_rdata;
   logic                  cpu_ram_we = 1'b0;
   logic [15:0]           cpu_ram_addr = 16'h0000;
   logic                  cpu_per_we = 1'b0;
   logic [15:0]           cpu_per_addr = 16'h0000;
   logic [7:0]            channel_irq_flag;
   int                    err_count = 0;
   int                    total_checks = 0;
   int                    cycles = 0;
   logic [15:0]           rd_val;
   logic [15:0]           per_rd_q [$];
   logic [15:0]           per_wa_q [$];
   logic [15:0]           ram_ra_q [$];
   logic [15:0]           ram_wa_q [$];
   logic [15:0]           ram_wd_q [$];

   always #5 ref_clk = ~ref_clk;

   multi_channel_dma_controller dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_irq(periph_irq),
      .periph_ram_addr(periph_ram_addr), .xfer_bus(xfer_bus), .ram_rdata(ram_rdata),
      .per_rdata(per_rdata), .cpu_ram_we(cpu_ram_we), .cpu_ram_addr(cpu_ram_addr),
      .cpu_per_we(cpu_per_we), .cpu_per_addr(cpu_per_addr), .channel_irq_flag(channel_irq_flag));

   dma_far_side far_u (.ref_clk(ref_clk), .rst_b(rst_b), .xfer_bus(xfer_bus),
      .ram_rdata(ram_rdata), .per_rdata(per_rdata));

   // ----------------------------------------
   // Bus monitor and hang guard
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (xfer_bus.per_re === 1'b1) per_rd_q.push_back(xfer_bus.per_addr);
      if (xfer_bus.per_we === 1'b1) per_wa_q.push_back(xfer_bus.per_addr);
      if (xfer_bus.ram_re === 1'b1) ram_ra_q.push_back(xfer_bus.ram_addr);
      if (xfer_bus.ram_we === 1'b1) ram_wa_q.push_back(xfer_bus.ram_addr);
      if (xfer_bus.ram_we === 1'b1) ram_wd_q.push_back(xfer_bus.ram_wdata);
      if (cycles > 20000) begin
         err_count++;
         $display("MISMATCH t=%0t run did not finish", $time);
         report_and_stop();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   function automatic logic [6:0] ci(input logic [2:0] ch, input logic [2:0] slot);
      return {1'b0, ch, slot};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [6:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task automatic wait_irq(input int ch);
      int n;
      n = 0;
      while (channel_irq_flag[ch] !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check({15'h0000, channel_irq_flag[ch]}, 16'h0001, "block done flag");
      @(posedge ref_clk);
   endtask

   task automatic force_one(input logic [2:0] ch);
      reg_write(ci(ch, 3'h1), 16'h8000);
      wait_irq(ch);
   endtask

   task automatic pulse(input int code);
      @(posedge ref_clk);
      periph_irq[code] <= 1'b1;
      @(posedge ref_clk);
      periph_irq[code] <= 1'b0;
   endtask

   task automatic setup(input logic [2:0] ch, input logic [15:0] pad, input logic [15:0] sta,
                        input logic [15:0] cnt, input logic [15:0] con);
      reg_write(ci(ch, 3'h4), pad);
      reg_write(ci(ch, 3'h2), sta);
      reg_write(ci(ch, 3'h5), cnt);
      reg_write(ci(ch, 3'h0), con);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic regs_scenario();
      reg_write(ci(3'h7, 3'h0), 16'h7FFF);
      reg_read(ci(3'h7, 3'h0));
      check(rd_val, 16'h7833, "control unused bits");
      reg_write(ci(3'h7, 3'h1), 16'h007F);
      reg_read(ci(3'h7, 3'h1));
      check(rd_val, 16'h007F, "request code");
      reg_read(7'h42);
      check(rd_val, 16'h0000, "unmapped read");
      reg_write(ci(3'h7, 3'h0), 16'h0000);
   endtask

   task automatic force_scenario();
      setup(3'h0, 16'h0300, 16'h0010, 16'h0000, 16'h8001);
      cpu_ram_we <= 1'b1;
      cpu_ram_addr <= 16'h0010;
      force_one(3'h0);
      cpu_ram_we <= 1'b0;
      check(per_rd_q[0], 16'h0300, "source is peripheral");
      check(ram_wa_q[0], 16'h0010, "ram destination");
      check(ram_wd_q[0], 16'hA6A5, "word moved");
      reg_read(ci(3'h0, 3'h0));
      check(rd_val, 16'h0001, "one-shot enable off");
      reg_read(ci(3'h0, 3'h1));
      check(rd_val, 16'h0000, "force self clears");
      reg_read(ci(3'h0, 3'h2));
      check(rd_val, 16'h0010, "pointer back at start");
      reg_read(7'h40);
      check(rd_val, 16'h0001, "ram write collision");
      reg_write(7'h40, 16'h0000);
      reg_read(7'h40);
      check(rd_val, 16'h0000, "collision cleared");
   endtask

   task automatic request_scenario();
      int n;
      n = 0;
      per_wa_q.delete();
      ram_ra_q.delete();
      reg_write(ci(3'h1, 3'h1), 16'h000A);
      setup(3'h1, 16'h0248, 16'h0010, 16'h0001, 16'hF000);
      pulse(10);
      wait_irq(1);
      reg_read(ci(3'h1, 3'h2));
      check(rd_val, 16'h0011, "pointer readback");
      pulse(10);
      cpu_per_we <= 1'b1;
      cpu_per_addr <= 16'h0248;
      // Half mode: no flag may follow the block end
      repeat (8) begin
         #1;
         if (channel_irq_flag[1] === 1'b1) n++;
         @(posedge ref_clk);
      end
      cpu_per_we <= 1'b0;
      check(16'(n), 16'h0000, "no flag at block end");
      check(per_wa_q.size(), 16'h0002, "count plus one units");
      check(per_wa_q[1], 16'h0248, "peripheral destination");
      check(ram_ra_q[1], 16'h0011, "byte post increment");
      reg_read(ci(3'h1, 3'h0));
      check(rd_val, 16'hF000, "continuous stays on");
      reg_read(7'h40);
      check(rd_val, 16'h0200, "peripheral write collision");
      reg_write(ci(3'h1, 3'h0), 16'h0000);
   endtask

   task automatic priority_scenario();
      per_rd_q.delete();
      reg_write(ci(3'h3, 3'h1), 16'h000D);
      reg_write(ci(3'h2, 3'h1), 16'h000D);
      setup(3'h3, 16'h0302, 16'h0030, 16'h0000, 16'h8001);
      setup(3'h2, 16'h0300, 16'h0020, 16'h0000, 16'h8001);
      pulse(13);
      wait_irq(3);
      check(per_rd_q[0], 16'h0300, "lowest channel first");
      check(per_rd_q[1], 16'h0302, "next channel after");
      reg_read(7'h41);
      check(rd_val, 16'h0300, "last channel status");
   endtask

   task automatic mode_scenario();
      ram_wa_q.delete();
      periph_ram_addr[4] <= 16'h0050;
      reg_write(ci(3'h4, 3'h4), 16'h0140);
      reg_write(ci(3'h4, 3'h2), 16'h0040);
      for (int m = 1; m < 4; m++) begin
         reg_write(ci(3'h4, 3'h0), 16'h8801 | (16'(m) << 4));
         force_one(3'h4);
         check(ram_wa_q[m - 1], (m == 1) ? 16'h0040 : 16'h0050, "addressing mode");
         check(per_wa_q[per_wa_q.size() - 1], 16'h0140, "null write");
      end
      ram_wa_q.delete();
      setup(3'h5, 16'h0300, 16'h0060, 16'h0000, 16'h8003);
      reg_write(ci(3'h5, 3'h3), 16'h0070);
      force_one(3'h5);
      force_one(3'h5);
      check(ram_wa_q[1], 16'h0070, "second buffer");
      reg_read(ci(3'h5, 3'h0));
      check(rd_val, 16'h0003, "one-shot ping-pong stops");
      // Continuous ping-pong keeps swapping buffers
      reg_write(ci(3'h5, 3'h0), 16'h8002);
      repeat (3) force_one(3'h5);
      check(ram_wa_q[4], 16'h0060, "continuous ping-pong wraps");
      reg_read(ci(3'h5, 3'h0));
      check(rd_val, 16'h8002, "continuous ping-pong stays on");
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence after five cycles of reset
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      regs_scenario();
      force_scenario();
      request_scenario();
      priority_scenario();
      mode_scenario();
      report_and_stop();
   end
endmodule

`default_nettype wire
